/* File: bench/dsi3_master_model.sv */
// DSI3 bus master model: sends whole command frames as one-cycle strobes.
// Assumes the block samples a frame on the edge where the strobe is high.
`timescale 1ns/100ps
`default_nettype none
module dsi3_master_model (
  input wire logic sys_clk_i,
  output logic cmd_valid_o,
  output logic [31:0] cmd_frame_o
);
  import dsi3_periodic_data_collection_mode_pkg::*;
  // ************************************************************
  // Frame building
  // ************************************************************
  initial begin
    cmd_valid_o = 1'b0;
    cmd_frame_o = 32'h0;
  end
  function automatic logic [7:0] crc8(input logic [23:0] hdr);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      c = (c[7] ^ hdr[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8
  // Bad flips one CRC bit so the check must fail
  task automatic send(input logic [3:0] a, input logic [3:0] c, input logic [15:0] d, input logic bad);
    logic [31:0] f;
    f = {a, c, d, 8'h00};
    f[7:0] = crc8(f[31:8]) ^ {7'h0, bad};
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_frame_o <= f;
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b0;
    // Idle line never shows a stale frame
    cmd_frame_o <= ~f;
  endtask : send
endmodule : dsi3_master_model
`default_nettype wire

/* File: bench/dsi3_periodic_data_collection_mode_entry_decoder_tb.sv */
// Self-checking bench: Wishbone register tasks and command frame tasks.
// Assumes the master model sends frames; expectations come from the constants.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module dsi3_periodic_data_collection_mode_entry_decoder_tb;
  import dsi3_periodic_data_collection_mode_pkg::*;
  logic sys_clk_i, srst_i, cmd_valid_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, resp_valid_o;
  logic init_complete_o, cr_mode_active_o, periodic_data_collection_mode_active_o, bdm_active_o, config_lock_o;
  logic user_array_verify_en_o, bcast_decode_en_o, bdm_frag_decode_en_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] cmd_frame_i, resp_frame_o, wb_dat_i, wb_dat_o;
  int n_errors = 0;
  int n_tests = 0;
  // ************************************************************
  // Instances and clock
  // ************************************************************
  dsi3_master_model m (.sys_clk_i, .cmd_valid_o(cmd_valid_i), .cmd_frame_o(cmd_frame_i));
  dsi3_periodic_data_collection_mode_entry_decoder dut (.sys_clk_i, .srst_i, .cmd_valid_i, .cmd_frame_i, .resp_valid_o,
    .resp_frame_o, .init_complete_o, .cr_mode_active_o, .periodic_data_collection_mode_active_o, .bdm_active_o, .config_lock_o,
    .user_array_verify_en_o, .bcast_decode_en_o, .bdm_frag_decode_en_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o);
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic rst();
    srst_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
  endtask : rst
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    logic got;
    got = 1'b0;
    q = 32'h0;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // Ack and read data taken on the rising edge, before the slave updates them
    for (int n = 0; n < 20 && !got; n++) begin
      @(posedge sys_clk_i);
      if (wb_ack_o === 1'b1) begin
        got = 1'b1;
        q = wb_dat_o;
      end
    end
    if (!got) begin
      n_errors++;
      final_report();
    end
    // Release on the same edge where ack was seen high
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask : wr
  task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] ex);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    `CHK(nm, ex, q)
  endtask : rd
  // Full compares the data field too; reserved answers may carry any data
  task automatic frm(input logic [3:0] a, input logic [3:0] c, input logic [15:0] d, input logic bad,
                     input logic ex, input logic full, input logic [23:0] hdr);
    m.send(a, c, d, bad);
    #1;
    `CHK("resp_valid", ex, resp_valid_o)
    if (ex) begin
      `CHK("resp_head", hdr[23:16], resp_frame_o[31:24])
      if (full) `CHK("resp_data", hdr[15:0], resp_frame_o[23:8])
      `CHK("resp_crc", m.crc8(resp_frame_o[31:8]), resp_frame_o[7:0])
    end
  endtask : frm
  task automatic st(input logic i, input logic p, input logic b);
    `CHK("modes", {i, ~i, p, b, i, i, i, b}, {init_complete_o, cr_mode_active_o, periodic_data_collection_mode_active_o,
      bdm_active_o, config_lock_o, user_array_verify_en_o, bcast_decode_en_o, bdm_frag_decode_en_o})
    rd("status", OFS_STATUS, {28'h0, b, p, ~i, i});
  endtask : st
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    srst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
    rst();
    st(1'b0, 1'b0, 1'b0);
    rd("node", OFS_NODE_ADDR, 32'h0);
    rd("tcfg", OFS_TIMING_CFG, 32'h0);
    wr(4'hc, 32'hff, 4'hf);
    rd("unmapped", 4'hc, 32'h0);
    wr(OFS_NODE_ADDR, 32'h5, 4'hf);
    wr(OFS_NODE_ADDR, 32'h9, 4'he);
    rd("node", OFS_NODE_ADDR, 32'h5);
    wr(OFS_TIMING_CFG, 32'ha1, 4'hf);
    st(1'b0, 1'b0, 1'b0);
    $display("test registers done");
    for (int c = 1; c < 16; c++) begin
      if (c != 8 && c != 11) frm(4'h5, 4'(c), 16'(c * 16'h1111), 1'b0, 1'b1, 1'b0, {8'h50 | 8'(c), 16'h0});
    end
    frm(4'h3, 4'h1, 16'h0, 1'b0, 1'b0, 1'b0, 24'h0);
    frm(4'h5, 4'h2, 16'h0, 1'b1, 1'b0, 1'b0, 24'h0);
    frm(4'h3, CMD_ENTER_PERIODIC_DATA_COLLECTION_MODE, 16'h0, 1'b0, 1'b0, 1'b0, 24'h0);
    frm(4'h5, CMD_ENTER_PERIODIC_DATA_COLLECTION_MODE, 16'h0, 1'b1, 1'b0, 1'b0, 24'h0);
    st(1'b0, 1'b0, 1'b0);
    $display("test reserved done");
    frm(4'h5, CMD_ENTER_PERIODIC_DATA_COLLECTION_MODE, 16'h0, 1'b0, 1'b1, 1'b1, 24'h5b0a00);
    st(1'b1, 1'b1, 1'b1);
    frm(4'h5, 4'h1, 16'h0, 1'b0, 1'b0, 1'b0, 24'h0);
    frm(4'h5, CMD_ENTER_PERIODIC_DATA_COLLECTION_MODE, 16'h0, 1'b0, 1'b0, 1'b0, 24'h0);
    wr(OFS_TIMING_CFG, 32'h0, 4'hf);
    rd("tcfg", OFS_TIMING_CFG, 32'ha1);
    wr(OFS_STATUS, 32'h0, 4'hf);
    st(1'b1, 1'b1, 1'b1);
    $display("test addressed entry done");
    rst();
    st(1'b0, 1'b0, 1'b0);
    wr(OFS_NODE_ADDR, 32'h7, 4'hf);
    frm(GLOBAL_ADDR, CMD_ENTER_PERIODIC_DATA_COLLECTION_MODE, 16'h0, 1'b0, 1'b0, 1'b0, 24'h0);
    st(1'b1, 1'b1, 1'b0);
    rst();
    frm(GLOBAL_ADDR, CMD_ENTER_PERIODIC_DATA_COLLECTION_MODE, 16'h0, 1'b0, 1'b0, 1'b0, 24'h0);
    st(1'b1, 1'b1, 1'b0);
    $display("test global entry done");
    final_report();
  end
endmodule : dsi3_periodic_data_collection_mode_entry_decoder_tb
`default_nettype wire

/* File: design/dsi3_crc8.sv */
// Combinational CRC-8 over a 24-bit header, MSB first.
// Assumes the caller registers the result where timing matters.
`timescale 1ns/100ps
`default_nettype none
module dsi3_crc8 #(
  parameter logic [7:0] POLY = dsi3_periodic_data_collection_mode_pkg::CRC_POLY,
  parameter logic [7:0] SEED = dsi3_periodic_data_collection_mode_pkg::CRC_SEED
) (
  input wire logic [23:0] data_i,
  output logic [7:0] crc_o
);
  always_comb begin
    logic [7:0] acc;
    acc = SEED;
    for (int i = 23; i >= 0; i--) begin
      if (acc[7] ^ data_i[i]) begin
        acc = {acc[6:0], 1'b0} ^ POLY;
      end else begin
        acc = {acc[6:0], 1'b0};
      end
    end
    crc_o = acc;
  end
endmodule : dsi3_crc8
`default_nettype wire

/* File: design/dsi3_periodic_data_collection_mode_entry_decoder.sv */
// Enter-PERIODIC_DATA_COLLECTION_MODE and reserved command decoder with DSI3 mode gating.
// Assumes whole command frames arrive as one-cycle strobes from the bit receiver.
//
// Overview of operation
// - Own-address Enter PERIODIC_DATA_COLLECTION_MODE sets init flag, enters PERIODIC_DATA_COLLECTION_MODE, responds.
// - Global-address Enter PERIODIC_DATA_COLLECTION_MODE sets init flag and enters PERIODIC_DATA_COLLECTION_MODE, any node address.
// - Global-address Enter PERIODIC_DATA_COLLECTION_MODE gets no response.
// - Enter PERIODIC_DATA_COLLECTION_MODE to any other address is ignored.
// - Before PERIODIC_DATA_COLLECTION_MODE only command-and-response mode is active.
// - After PERIODIC_DATA_COLLECTION_MODE: command mode off, PERIODIC_DATA_COLLECTION_MODE on, diagnostics follow enable bit.
// - Init flag locks timing configuration, not the node address, and enables user array verification.
// - Init flag cleared only by reset.
// - Enter PERIODIC_DATA_COLLECTION_MODE frame: address, code 1011, sixteen zero bits, CRC.
// - Enter PERIODIC_DATA_COLLECTION_MODE response: own address, 1011, chip time in bits 11..8, CRC.
// - Reserved codes answered only on own address with valid CRC.
// - Reserved answer echoes address and code with a correct CRC.
// - Codes 1..7, 9, 10, 12..15 are reserved, data ignored.
// - Reserved code to another address is ignored silently.
// - After init, broadcast reads are decoded, and diagnostic fragments only while the enable bit is set.
`timescale 1ns/100ps
`default_nettype none
module dsi3_periodic_data_collection_mode_entry_decoder (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Command frames from the receiver
  input wire logic cmd_valid_i,
  input wire logic [31:0] cmd_frame_i,
  // Response frames to the transmitter
  output logic resp_valid_o,
  output logic [31:0] resp_frame_o,
  // Mode and lock status
  output logic init_complete_o,
  output logic cr_mode_active_o,
  output logic periodic_data_collection_mode_active_o,
  output logic bdm_active_o,
  output logic config_lock_o,
  output logic user_array_verify_en_o,
  output logic bcast_decode_en_o,
  output logic bdm_frag_decode_en_o,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o
);
  import dsi3_periodic_data_collection_mode_pkg::*;

  // ************************************************************
  // Register file
  // ************************************************************
  logic [3:0] node_addr_ff;
  logic [3:0] chip_time_ff;
  logic background_diag_enable_ff;
  mode_type mode_ff;
  mode_type nxt_mode;
  logic wr_en;
  logic [31:0] rd_data;

  dsi3_wb_slave u_wb (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .rd_data_i(rd_data),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .wr_en_o(wr_en)
  );

  wire in_periodic_data_collection_mode = (mode_ff == MODE_PERIODIC_DATA_COLLECTION_MODE);
  wire wr_node = wr_en & (wb_adr_i == OFS_NODE_ADDR);
  // Timing config is frozen once initialisation is declared complete
  wire wr_tcfg = wr_en & (wb_adr_i == OFS_TIMING_CFG) & ~in_periodic_data_collection_mode;
  wire [31:0] tcfg_word = 32'(chip_time_ff) << TCFG_CHIP_LSB | 32'(background_diag_enable_ff) << TCFG_BDM_BIT;
  wire [31:0] stat_word = 32'(init_complete_o) << STAT_INIT_BIT | 32'(cr_mode_active_o) << STAT_CR_BIT
                        | 32'(periodic_data_collection_mode_active_o) << STAT_PERIODIC_DATA_COLLECTION_MODE_BIT | 32'(bdm_active_o) << STAT_BDM_BIT;
  assign rd_data = (wb_adr_i == OFS_NODE_ADDR) ? {28'h0, node_addr_ff} :
                   (wb_adr_i == OFS_TIMING_CFG) ? tcfg_word :
                   (wb_adr_i == OFS_STATUS) ? stat_word : 32'h0;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      node_addr_ff <= NODE_ADDR_RST;
      chip_time_ff <= CHIP_TIME_RST;
      background_diag_enable_ff <= BACKGROUND_DIAG_ENABLE_RST;
    end else begin
      if (wr_node) begin
        node_addr_ff <= wb_dat_i[3:0];
      end
      if (wr_tcfg) begin
        chip_time_ff <= wb_dat_i[TCFG_CHIP_LSB +: 4];
        background_diag_enable_ff <= wb_dat_i[TCFG_BDM_BIT];
      end
    end
  end

  // ************************************************************
  // Frame decode
  // ************************************************************
  wire [3:0] rx_addr = cmd_frame_i[FRM_ADDR_LSB +: 4];
  wire [3:0] rx_cmd = cmd_frame_i[FRM_CMD_LSB +: 4];
  wire [7:0] rx_crc = cmd_frame_i[7:0];
  logic [7:0] calc_crc;

  dsi3_crc8 u_rx_crc (
    .data_i(cmd_frame_i[31:8]),
    .crc_o(calc_crc)
  );

  // Only command-and-response mode takes these frames; a bad CRC drops the frame
  wire frame_ok = cmd_valid_i & ~in_periodic_data_collection_mode & (calc_crc == rx_crc);
  wire own_hit = (rx_addr == node_addr_ff);
  wire glb_hit = (rx_addr == GLOBAL_ADDR);
  wire is_enter = (rx_cmd == CMD_ENTER_PERIODIC_DATA_COLLECTION_MODE);
  // Data field is not inspected for any code handled here
  wire is_rsvd = (rx_cmd != CMD_NONE) & (rx_cmd != CMD_REG_WRITE) & ~is_enter;
  // Global wins when the node address is still zero: silent entry
  wire enter_glb = frame_ok & is_enter & glb_hit;
  wire enter_own = frame_ok & is_enter & own_hit & ~glb_hit;
  wire rsvd_own = frame_ok & is_rsvd & own_hit;

  // ************************************************************
  // Mode state
  // ************************************************************
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_CR: begin
        if (enter_glb | enter_own) begin
          nxt_mode = MODE_PERIODIC_DATA_COLLECTION_MODE;
        end
      end
      MODE_PERIODIC_DATA_COLLECTION_MODE: begin
        nxt_mode = MODE_PERIODIC_DATA_COLLECTION_MODE;
      end
      default: begin
        nxt_mode = MODE_CR;
      end
    endcase
  end

  // Mode outputs are registered from next-state so they track mode_ff exactly
  wire nxt_init = (nxt_mode == MODE_PERIODIC_DATA_COLLECTION_MODE);
  wire nxt_background_diag_enable = wr_tcfg ? wb_dat_i[TCFG_BDM_BIT] : background_diag_enable_ff;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mode_ff <= MODE_CR;
      init_complete_o <= 1'b0;
      cr_mode_active_o <= 1'b1;
      periodic_data_collection_mode_active_o <= 1'b0;
      bdm_active_o <= 1'b0;
      config_lock_o <= 1'b0;
      user_array_verify_en_o <= 1'b0;
      bcast_decode_en_o <= 1'b0;
      bdm_frag_decode_en_o <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      init_complete_o <= nxt_init;
      cr_mode_active_o <= ~nxt_init;
      periodic_data_collection_mode_active_o <= nxt_init;
      bdm_active_o <= nxt_init & nxt_background_diag_enable;
      config_lock_o <= nxt_init;
      user_array_verify_en_o <= nxt_init;
      bcast_decode_en_o <= nxt_init;
      bdm_frag_decode_en_o <= nxt_init & nxt_background_diag_enable;
    end
  end

  // ************************************************************
  // Response build
  // ************************************************************
  // Reserved answers echo the received data; any data value is legal there
  wire [15:0] enter_data = 16'(chip_time_ff) << (RSP_CHIP_LSB - FRM_DATA_LSB);
  wire [23:0] tx_head = enter_own ? {node_addr_ff, CMD_ENTER_PERIODIC_DATA_COLLECTION_MODE, enter_data} :
                        {node_addr_ff, rx_cmd, cmd_frame_i[FRM_DATA_LSB +: 16]};
  logic [7:0] tx_crc;

  dsi3_crc8 u_tx_crc (
    .data_i(tx_head),
    .crc_o(tx_crc)
  );

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      resp_valid_o <= 1'b0;
      resp_frame_o <= 32'h0;
    end else begin
      resp_valid_o <= enter_own | rsvd_own;
      if (enter_own | rsvd_own) begin
        resp_frame_o <= {tx_head, tx_crc};
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  own_enter_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    enter_own |=> resp_valid_o && init_complete_o && periodic_data_collection_mode_active_o)
    else $error("own-address entry did not respond or enter PERIODIC_DATA_COLLECTION_MODE");

  glob_enter_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    frame_ok && is_enter && glb_hit |=> init_complete_o && periodic_data_collection_mode_active_o)
    else $error("global entry did not enter PERIODIC_DATA_COLLECTION_MODE");

  glob_silent_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    enter_glb |=> !resp_valid_o)
    else $error("global entry produced a response");

  other_addr_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cmd_valid_i && is_enter && !own_hit && !glb_hit && !in_periodic_data_collection_mode |=> !resp_valid_o && !init_complete_o)
    else $error("entry to foreign address acted");

  pre_mode_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !init_complete_o |-> cr_mode_active_o && !periodic_data_collection_mode_active_o && !bdm_active_o)
    else $error("wrong modes before PERIODIC_DATA_COLLECTION_MODE");

  post_mode_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    init_complete_o |-> !cr_mode_active_o && periodic_data_collection_mode_active_o && (bdm_active_o == background_diag_enable_ff))
    else $error("wrong modes after PERIODIC_DATA_COLLECTION_MODE");

  cfg_lock_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    init_complete_o && wr_en && wb_adr_i == OFS_TIMING_CFG |=> $stable(chip_time_ff) && $stable(background_diag_enable_ff))
    else $error("locked timing config was written");

  init_sticky_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    init_complete_o |=> init_complete_o && config_lock_o && user_array_verify_en_o)
    else $error("init flag or lock dropped without reset");

  enter_fmt_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    enter_own |=> resp_frame_o[31:8] == {$past(node_addr_ff), CMD_ENTER_PERIODIC_DATA_COLLECTION_MODE, 4'h0, $past(chip_time_ff), 8'h0})
    else $error("entry response fields wrong");

  rsvd_echo_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    rsvd_own |=> resp_valid_o && resp_frame_o[31:24] == {$past(node_addr_ff), $past(rx_cmd)})
    else $error("reserved response echo wrong");

  rsvd_ignore_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cmd_valid_i && is_rsvd && !own_hit |=> !resp_valid_o)
    else $error("reserved code to foreign address answered");

  bad_crc_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cmd_valid_i && calc_crc != rx_crc && !init_complete_o |=> !resp_valid_o && !init_complete_o)
    else $error("bad CRC frame acted");

  decode_en_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    bcast_decode_en_o == init_complete_o && bdm_frag_decode_en_o == bdm_active_o)
    else $error("decode enables disagree with mode");

  // Cross-checks written from the code lists and mode table; some reuse decode wires such as wr_tcfg and enter_own
  periodic_data_collection_mode_deaf_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    in_periodic_data_collection_mode |=> !resp_valid_o)
    else $error("frame answered in PERIODIC_DATA_COLLECTION_MODE");

  mode_legal_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    mode_ff == MODE_CR || mode_ff == MODE_PERIODIC_DATA_COLLECTION_MODE)
    else $error("mode register holds an illegal code");

  lock_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    config_lock_o |-> !wr_tcfg)
    else $error("timing config write enabled while locked");

  lock_track_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    config_lock_o == init_complete_o && user_array_verify_en_o == init_complete_o)
    else $error("lock or verify enable disagrees with init flag");

  init_cause_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    $rose(init_complete_o) |-> $past(enter_glb) || $past(enter_own))
    else $error("init flag set without an entry command");

  enter_code_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    resp_valid_o && resp_frame_o[27:24] == CMD_ENTER_PERIODIC_DATA_COLLECTION_MODE |-> init_complete_o)
    else $error("entry response without entering PERIODIC_DATA_COLLECTION_MODE");

  rsp_addr_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    resp_valid_o |-> resp_frame_o[31:28] == $past(node_addr_ff))
    else $error("response address is not the node address");

  bdm_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    bdm_active_o |-> periodic_data_collection_mode_active_o && background_diag_enable_ff)
    else $error("diagnostics active outside PERIODIC_DATA_COLLECTION_MODE or while disabled");

  cr_lock_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cr_mode_active_o |-> !config_lock_o && !bcast_decode_en_o)
    else $error("command mode active with lock or broadcast decode");

  // Reserved list spelled out so a slip in the decode is caught
  rsvd_code_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    rsvd_own |-> rx_cmd inside {[4'h1:4'h7], 4'h9, 4'ha, [4'hc:4'hf]})
    else $error("non-reserved code decoded as reserved");

  rsvd_hit_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cmd_valid_i && !in_periodic_data_collection_mode && own_hit && calc_crc == rx_crc && rx_cmd inside {[4'h1:4'h7], 4'h9, 4'ha, [4'hc:4'hf]}
    |=> resp_valid_o)
    else $error("reserved code to own address not answered");
endmodule : dsi3_periodic_data_collection_mode_entry_decoder
`default_nettype wire

/* File: design/dsi3_periodic_data_collection_mode_pkg.sv */
// Constants shared by the PERIODIC_DATA_COLLECTION_MODE entry decoder, its CRC unit and its bench.
// Assumes a 32-bit command frame: address, command, 16 data bits, 8 CRC bits.
package dsi3_periodic_data_collection_mode_pkg;
  // ************************************************************
  // Frame layout and command codes
  // ************************************************************
  localparam int FRM_ADDR_LSB = 28;
  localparam int FRM_CMD_LSB = 24;
  localparam int FRM_DATA_LSB = 8;
  localparam int RSP_CHIP_LSB = 16;
  localparam logic [3:0] GLOBAL_ADDR = 4'h0;
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_REG_WRITE = 4'h8;
  localparam logic [3:0] CMD_ENTER_PERIODIC_DATA_COLLECTION_MODE = 4'hb;
  localparam logic [7:0] CRC_POLY = 8'h2f;
  localparam logic [7:0] CRC_SEED = 8'hff;
  // ************************************************************
  // Register map (byte offsets) and fields
  // ************************************************************
  localparam logic [3:0] OFS_NODE_ADDR = 4'h0;
  localparam logic [3:0] OFS_TIMING_CFG = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam int TCFG_BDM_BIT = 0;
  localparam int TCFG_CHIP_LSB = 4;
  localparam int STAT_INIT_BIT = 0;
  localparam int STAT_CR_BIT = 1;
  localparam int STAT_PERIODIC_DATA_COLLECTION_MODE_BIT = 2;
  localparam int STAT_BDM_BIT = 3;
  localparam logic [3:0] NODE_ADDR_RST = 4'h0;
  localparam logic [3:0] CHIP_TIME_RST = 4'h0;
  localparam logic BACKGROUND_DIAG_ENABLE_RST = 1'b0;
  // ************************************************************
  // Mode state
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_CR = 2'b01,
    MODE_PERIODIC_DATA_COLLECTION_MODE = 2'b10
  } mode_type;
endpackage : dsi3_periodic_data_collection_mode_pkg

/* File: design/dsi3_wb_slave.sv */
// Classic Wishbone slave front end: one wait state, registered ack and data.
// Assumes the master holds the request until it samples ack.
`timescale 1ns/100ps
`default_nettype none
module dsi3_wb_slave (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] rd_data_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic wr_en_o
);
  logic ack_ff;
  logic [31:0] dat_ff;
  wire req = wb_cyc_i & wb_stb_i;

  // Write lands on the edge where the master sees ack
  assign wr_en_o = req & ack_ff & wb_we_i & wb_sel_i[0];
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= req & ~ack_ff;
      dat_ff <= (req & ~ack_ff & ~wb_we_i) ? rd_data_i : 32'h0;
    end
  end
  // Unused upper write lanes: registers are eight bits wide
  wire unused_ok = &{1'b0, wb_dat_i[31:8], wb_sel_i[3:1]};
endmodule : dsi3_wb_slave
`default_nettype wire
